// ===== hdl/fls_consts.svh
/*
 * Constants of the floating-point load/store/operate stage sequencer: write-stage phases,
 * status-register field positions, trap-type codes, queue and buffer depths.
 * Assumes it is included by bare name from hdl/ and tb/ files.
 */
`ifndef FLS_CONSTS_SVH
`define FLS_CONSTS_SVH

`define FLS_FIFO_DEPTH   16
`define FLS_QUEUE_DEPTH  2
`define FLS_LAT_DEFAULT  8'h04
`define FLS_PH_W         2'h0
`define FLS_PH_WH1       2'h1
`define FLS_PH_WH2       2'h2
`define FLS_FTT_NONE     3'h0
`define FLS_FTT_IEEE     3'h1
`define FLS_FSR_RESET    32'h00000000
`define FLS_FSR_TEM      27:23
`define FLS_FSR_FTT      16:14
`define FLS_FSR_QNE      13
`define FLS_FSR_AEXC     9:5
`define FLS_FSR_CURRENT_EXCEPTION_FIELD     4:0

`endif

// ===== hdl/fls_pkg.sv
/*
 * Types shared by the stage sequencer: instruction classes, operate-queue states,
 * the decoded instruction record and the register write-back record.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package fls_pkg;

  typedef enum logic [3:0] {
    FLS_CL_NONE,
    FLS_LOAD_SINGLE_WORD,
    FLS_LOAD_DOUBLE_WORD,
    FLS_LOAD_STATUS_REG,
    FLS_STORE_SINGLE_WORD,
    FLS_STORE_DOUBLE_WORD,
    FLS_STORE_STATUS_REG,
    FLS_STORE_QUEUE_ENTRY,
    FLS_OPERATE_INSTRUCTION,
    FLS_BRANCH
  } fls_class_t;

  typedef enum logic [1:0] {FLS_Q_READ2, FLS_Q_COMPUTE, FLS_Q_CHECK, FLS_Q_UPDATE} fls_qstate_t;

  typedef struct packed {
    logic        v;
    fls_class_t  cls;
    logic [1:0]  kind;
    logic [4:0]  rd;
    logic [4:0]  rs1;
    logic [4:0]  rs2;
    logic [31:0] word;
    logic [31:0] addr;
  } fls_instr_t;

  typedef struct packed {
    logic        dbl;
    logic [4:0]  idx;
    logic [31:0] hi;
    logic [31:0] lo;
  } fls_wb_t;

endpackage

`default_nettype wire

// ===== hdl/fls_stream_if.sv
/*
 * Valid/ready stream between the sequencer and its write-back buffer.
 * Assumes both ends share one clock.
 */
`default_nettype none

interface fls_stream_if #(parameter int WIDTH = 8) ();
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface

`default_nettype wire

// ===== hdl/fls_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides and honest full and empty.
 * Assumes DEPTH is a power of two and reset is already synchronised.
 */
`default_nettype none

module fls_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic  i_clock,
  input  wire logic  i_reset_n,
  // Stream
  fls_stream_if.fifo port
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;

  wire logic do_push = port.push_valid && port.push_ready;
  wire logic do_pop  = port.pop_valid && port.pop_ready;

  assign port.push_ready = cnt_q != (AW+1)'(DEPTH);
  assign port.pop_valid  = cnt_q != '0;
  assign port.pop_data   = mem_q[rd_q];

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wr_q <= wr_q + 1'b1;
      if (do_pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge i_clock) begin
    if (do_push) mem_q[wr_q] <= port.push_data;
  end
endmodule

`default_nettype wire

// ===== hdl/fls_pipeline.sv
/*
 * Stage sequencer of a floating-point coprocessor: decode, execute, write and extra write
 * stages for loads and stores, a two-entry operate queue, operand forwarding from the data
 * bus, trap flushing, and a write-back buffer in front of the register file.
 * Assumes host, data bus and arithmetic unit all run on i_clock; the arithmetic unit holds
 * its result and exception bits valid once the configured latency has passed.
 */
// Contract
// - Decode each load and check dependencies against older queued work.
// - Hold a load in execute while a dependency exists, else start it.
// - Single or status load: capture in write, commit in first extra stage.
// - Double load: upper word in write, lower in extra one, commit in extra two.
// - Followers may decode and execute while a load is still writing.
// - Register file changes only after the load's last extra stage.
// - A dependent follower takes load data forwarded straight from the bus.
// - Forwarded data reaches datapath or bus within one and a half cycles.
// - Host trap aborts the load without write and flushes its follower.
// - Hold a store on dependency, else read register file, status or queue.
// - Single or status store drives the bus from mid write stage.
// - Double store drives upper word mid write, lower word mid extra one.
// - Queue store drives entry address in write, instruction word in extra one.
// - Double and queue stores release the bus mid extra stage two.
// - Store decode and execute may overlap earlier write stages.
// - In exception mode queue stores drain every pending queue entry.
// - Operate reads first operand in execute, second in write, then computes.
// - Queued operate computes, checks exceptions, updates status, writes or traps.
// - Branch instructions are ignored.
// - The operate queue holds two entries of instruction and address.
// - Trap when enable mask AND current exceptions is nonzero; trapped results dropped.
// - Trap-type field becomes zero on normal completion, trap code otherwise.
`default_nettype none
`include "fls_consts.svh"

module fls_pipeline #(
  parameter logic [3:0][7:0] P_OP_LAT = {4{`FLS_LAT_DEFAULT}}
) (
  // Clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_reset_n,
  // Host integer unit
  input  wire logic               i_instr_valid,
  input  wire fls_pkg::fls_class_t i_instr_class,
  input  wire logic [1:0]         i_op_kind,
  input  wire logic [4:0]         i_rd,
  input  wire logic [4:0]         i_rs1,
  input  wire logic [4:0]         i_rs2,
  input  wire logic [31:0]        i_instr_word,
  input  wire logic [31:0]        i_instr_addr,
  input  wire logic               i_trap,
  output logic                    o_instr_ready,
  // Data bus
  input  wire logic [31:0]        i_data_bus,
  output logic [31:0]             o_data_bus,
  output logic                    o_data_oe_n,
  // Arithmetic unit
  output logic                    o_arith_start,
  output logic [1:0]              o_arith_kind,
  output logic [31:0]             o_arith_a,
  output logic [31:0]             o_arith_b,
  input  wire logic [31:0]        i_arith_result,
  input  wire logic [4:0]         i_arith_current_exception_field,
  // Status
  output logic                    o_fp_trap,
  output logic                    o_exc_mode,
  output logic [31:0]             o_fsr
);
  import fls_pkg::*;

  function automatic logic is_load(input fls_class_t c);
    return c inside {FLS_LOAD_SINGLE_WORD, FLS_LOAD_DOUBLE_WORD, FLS_LOAD_STATUS_REG};
  endfunction

  function automatic logic is_store(input fls_class_t c);
    return c inside {FLS_STORE_SINGLE_WORD, FLS_STORE_DOUBLE_WORD, FLS_STORE_STATUS_REG,
                     FLS_STORE_QUEUE_ENTRY};
  endfunction

  function automatic logic [1:0] last_phase(input fls_class_t c);
    return (c inside {FLS_LOAD_DOUBLE_WORD, FLS_STORE_DOUBLE_WORD, FLS_STORE_QUEUE_ENTRY})
      ? `FLS_PH_WH2 : `FLS_PH_WH1;
  endfunction

  logic              rst_meta_q;
  logic              rst_n_q;
  fls_instr_t        d_q;
  fls_instr_t        e_q;
  fls_instr_t        w_q;
  logic [1:0]        w_ph_q;
  logic [31:0]       cap_hi_q;
  logic [31:0]       cap_lo_q;
  logic [31:0]       st_hi_q;
  logic [31:0]       st_lo_q;
  logic [31:0]       rf_q [32];
  logic [31:0]       fsr_q;
  fls_instr_t        q_ins_q [`FLS_QUEUE_DEPTH];
  logic [31:0]       q_a_q [`FLS_QUEUE_DEPTH];
  fls_qstate_t       q_st_q;
  logic [7:0]        q_cnt_q;
  logic [4:0]        current_exception_field_q;
  logic [31:0]       res_q;
  logic              exc_mode_q;
  logic              e_hold;

  fls_stream_if #(.WIDTH($bits(fls_wb_t))) wb ();

  fls_fifo #(.WIDTH($bits(fls_wb_t)), .DEPTH(`FLS_FIFO_DEPTH)) u_wb_fifo (
    .i_clock   (i_clock),
    .i_reset_n (rst_n_q),
    .port      (wb.fifo)
  );

  // The release is synchronised; assertion stays asynchronous.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Write-unit decode and forwarding sources.
  wire logic       w_ld_reg = w_q.v && w_q.cls inside {FLS_LOAD_SINGLE_WORD, FLS_LOAD_DOUBLE_WORD};
  wire logic       w_ld_dbl = w_q.v && w_q.cls == FLS_LOAD_DOUBLE_WORD;
  wire logic       w_store  = w_q.v && is_store(w_q.cls);
  wire logic [4:0] w_hi_idx = w_ld_dbl ? {w_q.rd[4:1], 1'b0} : w_q.rd;
  wire logic [4:0] w_lo_idx = {w_q.rd[4:1], 1'b1};
  wire logic       w_last   = w_q.v && w_ph_q == last_phase(w_q.cls);
  wire logic       w_free   = !w_q.v || (w_last && (!w_ld_reg || wb.push_ready));
  wire logic       q_empty  = !q_ins_q[0].v;
  wire logic       q_full   = q_ins_q[1].v;

  // Returns {wait, data}. Buffered write-backs are not searched, so any pending one holds
  // the reader; this trades a few stall cycles for a much smaller comparator tree.
  function automatic logic [32:0] src_read(input logic [4:0] r);
    logic [32:0] v;
    v = {wb.pop_valid, rf_q[r]};
    for (int i = 0; i < `FLS_QUEUE_DEPTH; i++) begin
      if (q_ins_q[i].v && q_ins_q[i].rd == r) v[32] = 1'b1;
    end
    if (w_ld_reg && r == w_hi_idx) begin
      v = {wb.pop_valid, (w_ph_q == `FLS_PH_W) ? i_data_bus : cap_hi_q};
    end else if (w_ld_dbl && r == w_lo_idx) begin
      v = {wb.pop_valid || w_ph_q == `FLS_PH_W,
           (w_ph_q == `FLS_PH_WH1) ? i_data_bus : cap_lo_q};
    end
    return v;
  endfunction

  logic [32:0] rd_s, rd_even, rd_odd, rs1_v, rs2_v, hd_rs2;
  // The reads inside src_read would not wake a continuous assignment, so a process calls it.
  always_comb begin
    rd_s    = src_read(e_q.rd);
    rd_even = src_read({e_q.rd[4:1], 1'b0});
    rd_odd  = src_read({e_q.rd[4:1], 1'b1});
    rs1_v   = src_read(e_q.rs1);
    rs2_v   = src_read(e_q.rs2);
    hd_rs2  = src_read(q_ins_q[0].rs2);
  end

  // Execute-stage dependency and resource holds.
  always_comb begin
    unique case (e_q.cls)
      FLS_LOAD_SINGLE_WORD, FLS_LOAD_DOUBLE_WORD: e_hold = !w_free || rd_s[32];
      FLS_LOAD_STATUS_REG:     e_hold = !w_free || !q_empty;
      FLS_STORE_SINGLE_WORD:   e_hold = !w_free || rd_s[32];
      FLS_STORE_DOUBLE_WORD:   e_hold = !w_free || rd_even[32] || rd_odd[32];
      FLS_STORE_STATUS_REG:    e_hold = !w_free || (!q_empty && !exc_mode_q);
      FLS_STORE_QUEUE_ENTRY:   e_hold = !w_free || (!q_empty && !exc_mode_q);
      FLS_OPERATE_INSTRUCTION: e_hold = q_full || exc_mode_q || rs1_v[32] || rs2_v[32];
      default:                 e_hold = 1'b0;
    endcase
  end

  wire logic e_go   = e_q.v && !e_hold && !i_trap;
  wire logic mem_go = e_go && (is_load(e_q.cls) || is_store(e_q.cls));
  wire logic op_go  = e_go && e_q.cls == FLS_OPERATE_INSTRUCTION;
  wire logic d_adv  = !e_q.v || e_go;
  wire logic take   = i_instr_valid && o_instr_ready && !i_trap &&
                      !(i_instr_class inside {FLS_CL_NONE, FLS_BRANCH});
  wire fls_instr_t in_ins = '{1'b1, i_instr_class, i_op_kind, i_rd, i_rs1, i_rs2,
                              i_instr_word, i_instr_addr};

  assign o_instr_ready = !d_q.v || d_adv;

  // Operate queue head sequencing.
  wire logic q_upd   = q_ins_q[0].v && !exc_mode_q && q_st_q == FLS_Q_UPDATE;
  wire logic trap_now = q_upd && |(fsr_q[`FLS_FSR_TEM] & current_exception_field_q);
  wire logic op_wr   = q_upd && !trap_now;
  wire logic pop_st  = e_go && e_q.cls == FLS_STORE_QUEUE_ENTRY && q_ins_q[0].v;
  wire logic q_pop   = pop_st || op_wr;
  wire logic [1:0] q_used = 2'(q_ins_q[0].v) + 2'(q_ins_q[1].v) - 2'(q_pop);
  wire logic       q_wr_idx = q_used[0];

  assign wb.push_valid = w_last && w_ld_reg && !i_trap;
  assign wb.push_data  = {w_ld_dbl, w_q.rd, cap_hi_q, cap_lo_q};
  assign wb.pop_ready  = !op_wr;
  assign o_exc_mode    = exc_mode_q;
  assign o_fsr         = fsr_q;

  // Decode, execute and write stages.
  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      d_q      <= '0;
      e_q      <= '0;
      w_q      <= '0;
      w_ph_q   <= `FLS_PH_W;
      cap_hi_q <= '0;
      cap_lo_q <= '0;
      st_hi_q  <= '0;
      st_lo_q  <= '0;
    end else begin
      if (i_trap) d_q.v <= 1'b0;
      else if (o_instr_ready) d_q <= take ? in_ins : '0;
      if (i_trap) e_q.v <= 1'b0;
      else if (d_adv) e_q <= d_q;
      if (w_q.v && !w_last) w_ph_q <= w_ph_q + 2'h1;
      if (w_q.v && is_load(w_q.cls) && w_ph_q == `FLS_PH_W) cap_hi_q <= i_data_bus;
      if (w_ld_dbl && w_ph_q == `FLS_PH_WH1) cap_lo_q <= i_data_bus;
      if (w_free) begin
        w_q    <= mem_go ? e_q : '0;
        w_ph_q <= `FLS_PH_W;
      end
      if (i_trap && is_load(w_q.cls)) w_q.v <= 1'b0;
      if (mem_go) begin
        unique case (e_q.cls)
          FLS_STORE_SINGLE_WORD: st_hi_q <= rd_s[31:0];
          FLS_STORE_DOUBLE_WORD: begin
            st_hi_q <= rd_even[31:0];
            st_lo_q <= rd_odd[31:0];
          end
          FLS_STORE_STATUS_REG: begin
            st_hi_q <= fsr_q;
            st_hi_q[`FLS_FSR_QNE] <= !q_empty;
          end
          FLS_STORE_QUEUE_ENTRY: begin
            st_hi_q <= q_ins_q[0].addr;
            st_lo_q <= q_ins_q[0].word;
          end
          default: st_hi_q <= st_hi_q;
        endcase
      end
    end
  end

  // Bus drive changes at mid-cycle so a forwarded load word lands within 1.5 cycles.
  always_ff @(negedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_data_oe_n <= 1'b1;
      o_data_bus  <= '0;
    end else begin
      o_data_oe_n <= !(w_store && w_ph_q != last_phase(w_q.cls));
      o_data_bus  <= (w_ph_q == `FLS_PH_W) ? st_hi_q : st_lo_q;
    end
  end

  // Operate queue: two entries, head advances through its sequence.
  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      q_ins_q[0]    <= '0;
      q_ins_q[1]    <= '0;
      q_a_q[0]      <= '0;
      q_a_q[1]      <= '0;
      q_st_q        <= FLS_Q_READ2;
      q_cnt_q       <= '0;
      current_exception_field_q        <= '0;
      res_q         <= '0;
      o_arith_start <= 1'b0;
      o_arith_kind  <= '0;
      o_arith_a     <= '0;
      o_arith_b     <= '0;
    end else begin
      o_arith_start <= 1'b0;
      if (q_pop) begin
        q_ins_q[0]   <= q_ins_q[1];
        q_a_q[0]     <= q_a_q[1];
        q_ins_q[1].v <= 1'b0;
        q_st_q       <= FLS_Q_READ2;
      end else if (q_ins_q[0].v && !exc_mode_q) begin
        unique case (q_st_q)
          FLS_Q_READ2: begin
            o_arith_start <= 1'b1;
            o_arith_kind  <= q_ins_q[0].kind;
            o_arith_a     <= q_a_q[0];
            o_arith_b     <= hd_rs2[31:0];
            q_cnt_q       <= P_OP_LAT[q_ins_q[0].kind];
            q_st_q        <= FLS_Q_COMPUTE;
          end
          FLS_Q_COMPUTE: begin
            if (q_cnt_q <= 8'h01) q_st_q <= FLS_Q_CHECK;
            else q_cnt_q <= q_cnt_q - 8'h01;
          end
          FLS_Q_CHECK: begin
            current_exception_field_q <= i_arith_current_exception_field;
            res_q  <= i_arith_result;
            q_st_q <= FLS_Q_UPDATE;
          end
          FLS_Q_UPDATE: q_st_q <= FLS_Q_UPDATE;
        endcase
      end
      if (op_go) begin
        q_ins_q[q_wr_idx] <= e_q;
        q_a_q[q_wr_idx]   <= rs1_v[31:0];
      end
    end
  end

  // Status register, trap signalling and exception mode.
  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fsr_q      <= `FLS_FSR_RESET;
      o_fp_trap  <= 1'b0;
      exc_mode_q <= 1'b0;
    end else begin
      o_fp_trap <= trap_now;
      if (w_last && w_q.cls == FLS_LOAD_STATUS_REG && !i_trap) begin
        fsr_q <= cap_hi_q;
      end else if (q_upd) begin
        fsr_q[`FLS_FSR_CURRENT_EXCEPTION_FIELD] <= current_exception_field_q;
        fsr_q[`FLS_FSR_FTT]  <= trap_now ? `FLS_FTT_IEEE : `FLS_FTT_NONE;
        if (!trap_now) fsr_q[`FLS_FSR_AEXC] <= fsr_q[`FLS_FSR_AEXC] | current_exception_field_q;
      end
      if (trap_now) exc_mode_q <= 1'b1;
      else if (q_empty) exc_mode_q <= 1'b0;
    end
  end

  // Register file; an operate result takes the port and stalls the write-back buffer.
  always_ff @(posedge i_clock) begin
    if (op_wr) rf_q[q_ins_q[0].rd] <= res_q;
    if (wb.pop_valid && wb.pop_ready) begin
      if (wb.pop_data[$bits(fls_wb_t)-1]) begin
        rf_q[{wb.pop_data[68:65], 1'b0}] <= wb.pop_data[63:32];
        rf_q[{wb.pop_data[68:65], 1'b1}] <= wb.pop_data[31:0];
      end else begin
        rf_q[wb.pop_data[68:64]] <= wb.pop_data[63:32];
      end
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n_q);

  a_single_load_commit: assert property (
    (w_q.v && w_q.cls == FLS_LOAD_SINGLE_WORD && w_ph_q == `FLS_PH_W && !i_trap) ##1 !i_trap
    |-> wb.push_valid && wb.push_data[63:32] == $past(i_data_bus))
    else $error("single load not committed in first extra stage");
  a_double_load_commit: assert property (
    (w_ld_dbl && w_ph_q == `FLS_PH_W && !i_trap) ##1 !i_trap ##1 !i_trap
    |-> wb.push_valid && wb.push_data[31:0] == $past(i_data_bus))
    else $error("double load lower word not committed in extra stage two");
  a_commit_at_end: assert property (
    wb.push_valid |-> w_ph_q == last_phase(w_q.cls) && !i_trap)
    else $error("load committed before its last extra stage");
  a_trap_abort_load: assert property (
    (i_trap && w_q.v && is_load(w_q.cls)) |-> !wb.push_valid ##1 (!w_q.v && !e_q.v))
    else $error("trapped load not aborted");
  a_exec_hold: assert property (
    (e_q.v && e_hold && !i_trap) |=> e_q == $past(e_q))
    else $error("held instruction left execute");
  a_single_store_bus: assert property (
    (w_q.v && w_q.cls == FLS_STORE_SINGLE_WORD && w_ph_q == `FLS_PH_W)
    |-> (!o_data_oe_n && o_data_bus == st_hi_q) ##1 o_data_oe_n)
    else $error("single store bus timing wrong");
  a_double_store_bus: assert property (
    (w_q.v && w_q.cls == FLS_STORE_DOUBLE_WORD && w_ph_q == `FLS_PH_W)
    |-> (!o_data_oe_n && o_data_bus == st_hi_q) ##1 (!o_data_oe_n && o_data_bus == st_lo_q)
    ##1 o_data_oe_n)
    else $error("double store bus timing wrong");
  a_queue_store_bus: assert property (
    (w_q.v && w_q.cls == FLS_STORE_QUEUE_ENTRY && w_ph_q == `FLS_PH_W)
    |-> !o_data_oe_n ##1 (!o_data_oe_n && o_data_bus == st_lo_q) ##1 o_data_oe_n)
    else $error("queue store bus timing wrong");
  a_mask_trap: assert property (
    (q_upd && |(fsr_q[`FLS_FSR_TEM] & current_exception_field_q))
    |=> o_fp_trap && exc_mode_q && fsr_q[`FLS_FSR_FTT] == `FLS_FTT_IEEE)
    else $error("enabled exception did not trap");
  a_normal_ftt: assert property (
    (q_upd && !(|(fsr_q[`FLS_FSR_TEM] & current_exception_field_q)))
    |=> !o_fp_trap && fsr_q[`FLS_FSR_FTT] == `FLS_FTT_NONE)
    else $error("normal completion left trap type set");
  a_branch_ignored: assert property (
    (i_instr_valid && o_instr_ready && i_instr_class == FLS_BRANCH) |=> !d_q.v)
    else $error("branch entered decode");

  c_double_load: cover property (wb.push_valid && w_ld_dbl);
  c_forward_op: cover property (op_go && w_ld_reg && e_q.rs1 == w_hi_idx);
  c_op_trap: cover property (trap_now);
  c_queue_drain: cover property (pop_st && exc_mode_q);
endmodule

`default_nettype wire

// ===== tb/fls_host_model.sv
/*
 * Far side of the sequencer: shared data bus and arithmetic unit.
 * Assumes the bench calls serve at the edge that takes a load.
 */
`default_nettype none

module fls_host_model #(
  parameter int LAT = 4
) (
  input  wire logic        i_clock,
  input  wire logic [31:0] i_dev_data,
  input  wire logic        i_dev_oe_n,
  input  wire logic        i_start,
  input  wire logic [31:0] i_a,
  input  wire logic [31:0] i_b,
  input  wire logic [4:0]  i_current_exception_field,
  output logic [31:0]      o_bus,
  output logic [31:0]      o_result,
  output logic [4:0]       o_current_exception_field
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        drv_q = 1'b0;
  logic [31:0] val_q = 32'h0;
  logic [31:0] last_q = 32'h0;
  logic [31:0] sum_q = 32'h0;
  int          cnt_q = 0;
  // A released bus toggles each cycle, so stale data never passes for a capture.
  assign o_bus = !i_dev_oe_n ? i_dev_data : (drv_q ? val_q : ~last_q);
  // Results are garbage until the compute latency has run.
  assign o_result = (cnt_q >= LAT - 1) ? sum_q : ~sum_q;
  assign o_current_exception_field = (cnt_q >= LAT - 1) ? i_current_exception_field : ~i_current_exception_field;
  always @(posedge i_clock) begin
    last_q <= o_bus;
    if (i_start) begin
      sum_q <= i_a + i_b;
      cnt_q <= 1;
    end else if (cnt_q < LAT) begin
      cnt_q <= cnt_q + 1;
    end
  end
  task automatic serve(input logic dbl, input logic [31:0] hi, input logic [31:0] lo);
    @(posedge i_clock);
    @(posedge i_clock);
    drv_q <= 1'b1;
    val_q <= hi;
    @(posedge i_clock);
    drv_q <= dbl;
    val_q <= lo;
    if (dbl) begin
      @(posedge i_clock);
      drv_q <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// ===== tb/fls_pipeline_bench.sv
/*
 * Self-checking bench of the stage sequencer: loads, stores, operates, traps.
 * Assumes the host model is compiled before it.
 */
`default_nettype none
`include "fls_consts.svh"

module fls_pipeline_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import fls_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        valid = 1'b0;
  logic        trap = 1'b0;
  fls_class_t  cls = FLS_CL_NONE;
  logic [4:0]  rd = 5'h00;
  logic [4:0]  rs1 = 5'h00;
  logic [4:0]  rs2 = 5'h00;
  logic [4:0]  current_exception_field = 5'h00;
  logic [31:0] word = 32'h0;
  logic [31:0] addr = 32'h0;
  logic        ready, oe_n, start, fp_trap, exc_mode;
  logic [31:0] dout, bus, a, b, res, fpu_status_register;
  logic [4:0]  acexc;
  logic [1:0]  op_kind;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;

  fls_pipeline i_fls_pipeline (.i_clock(clock), .i_reset_n(reset_n), .i_instr_valid(valid),
    .i_instr_class(cls), .i_op_kind(2'h1), .i_rd(rd), .i_rs1(rs1), .i_rs2(rs2),
    .i_instr_word(word), .i_instr_addr(addr), .i_trap(trap), .o_instr_ready(ready),
    .i_data_bus(bus), .o_data_bus(dout), .o_data_oe_n(oe_n), .o_arith_start(start),
    .o_arith_kind(op_kind), .o_arith_a(a), .o_arith_b(b), .i_arith_result(res),
    .i_arith_current_exception_field(acexc), .o_fp_trap(fp_trap), .o_exc_mode(exc_mode), .o_fsr(fpu_status_register));
  fls_host_model i_fls_host_model (.i_clock(clock), .i_dev_data(dout), .i_dev_oe_n(oe_n),
    .i_start(start), .i_a(a), .i_b(b), .i_current_exception_field(current_exception_field), .o_bus(bus), .o_result(res),
    .o_current_exception_field(acexc));

  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Called at a rising edge; returns at the edge that takes the instruction.
  task automatic issue(input fls_class_t c, input logic [4:0] d, s1, s2);
    valid <= 1'b1;
    cls <= c;
    rd <= d;
    rs1 <= s1;
    rs2 <= s2;
    word <= 32'hA5A50000 + d;
    addr <= 32'h00004000 + d;
    @(negedge clock);
    for (int k = 0; k < 50 && ready !== 1'b1; k++) @(negedge clock);
    @(posedge clock);
  endtask
  task automatic idle(input int k);
    valid <= 1'b0;
    repeat (k) @(posedge clock);
  endtask
  task automatic ld(input fls_class_t c, input logic [4:0] d, input logic [31:0] hi, lo);
    issue(c, d, 5'h00, 5'h00);
    fork
      i_fls_host_model.serve(c == FLS_LOAD_DOUBLE_WORD, hi, lo);
    join_none
  endtask
  task automatic st(input fls_class_t c, input logic [4:0] d, input logic [31:0] hi, lo,
                    output int n);
    issue(c, d, 5'h00, 5'h00);
    idle(1);
    for (n = 1; n < 60 && oe_n !== 1'b0; n++) @(posedge clock);
    chk("store first word", hi, bus);
    @(posedge clock);
    if (c == FLS_STORE_DOUBLE_WORD || c == FLS_STORE_QUEUE_ENTRY) begin
      chk("store second word", lo, bus);
      @(posedge clock);
    end
    chk("bus released", 32'h1, {31'h0, oe_n});
  endtask

  task automatic t_loads();
    int n;
    ld(FLS_LOAD_SINGLE_WORD, 5'h01, 32'h3F800000, 32'h0);
    st(FLS_STORE_SINGLE_WORD, 5'h01, 32'h3F800000, 32'h0, n);
    chk("forwarded store latency", 32'h4, n);
    idle(8);
    ld(FLS_LOAD_DOUBLE_WORD, 5'h02, 32'h12345678, 32'h9ABCDEF0);
    idle(8);
    st(FLS_STORE_DOUBLE_WORD, 5'h02, 32'h12345678, 32'h9ABCDEF0, n);
    ld(FLS_LOAD_SINGLE_WORD, 5'h01, 32'h0BADF00D, 32'h0);
    idle(2);
    trap <= 1'b1;
    @(posedge clock);
    trap <= 1'b0;
    idle(8);
    st(FLS_STORE_SINGLE_WORD, 5'h01, 32'h3F800000, 32'h0, n);
  endtask

  task automatic t_ops();
    int n;
    ld(FLS_LOAD_SINGLE_WORD, 5'h04, 32'h00000011, 32'h0);
    idle(6);
    current_exception_field <= 5'h01;
    ld(FLS_LOAD_SINGLE_WORD, 5'h05, 32'h00000022, 32'h0);
    // The operate follows the load at once, so its first operand comes off the bus.
    issue(FLS_OPERATE_INSTRUCTION, 5'h06, 5'h05, 5'h04);
    idle(0);
    for (int k = 0; k < 30 && start !== 1'b1; k++) @(negedge clock);
    chk("forwarded first operand", 32'h22, a);
    chk("second operand", 32'h11, b);
    chk("operate kind", 32'h1, {30'h0, op_kind});
    @(posedge clock);
    st(FLS_STORE_SINGLE_WORD, 5'h06, 32'h00000033, 32'h0, n);
    @(negedge clock);
    chk("normal trap type", 32'h0, {29'h0, fpu_status_register[`FLS_FSR_FTT]});
    chk("accrued flags", 32'h1, {27'h0, fpu_status_register[`FLS_FSR_AEXC]});
    @(posedge clock);
    ld(FLS_LOAD_STATUS_REG, 5'h00, 32'h00800000, 32'h0);
    idle(6);
    @(negedge clock);
    chk("status load", 32'h00800000, fpu_status_register);
    @(posedge clock);
    issue(FLS_OPERATE_INSTRUCTION, 5'h07, 5'h04, 5'h05);
    idle(0);
    for (int k = 0; k < 40 && fp_trap !== 1'b1; k++) @(negedge clock);
    chk("operate trap", 32'h1, {31'h0, fp_trap});
    @(negedge clock);
    chk("exception mode", 32'h1, {31'h0, exc_mode});
    chk("trap type", 32'h1, {29'h0, fpu_status_register[`FLS_FSR_FTT]});
    @(posedge clock);
    st(FLS_STORE_QUEUE_ENTRY, 5'h00, 32'h00004007, 32'hA5A50007, n);
    idle(4);
    @(negedge clock);
    chk("queue drained", 32'h0, {31'h0, exc_mode});
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk("idle bus enable", 32'h1, {31'h0, oe_n});
    chk("status reset", 32'h0, fpu_status_register);
    issue(FLS_BRANCH, 5'h03, 5'h01, 5'h02);
    idle(6);
    chk("branch ignored", 32'h0, a);
    t_loads();
    idle(4);
    t_ops();
    results();
  end
endmodule

`default_nettype wire
